// ==== verilog/periodic_tick_timer.sv ====
// What this block does
// R01: 16-bit up-counter, free-running or modulo
// R02: flag set when counter equals period
// R03: after period match restart from zero
// R04: flag cleared by status read then zero write
// R05: overflow between the steps blocks clear
// R06: writing one to flag ignored; reset clears
// R07: enable bit gates interrupt request; reset clears
// R08: halt bit freezes counter; reset sets it
// R09: clear strobe zeroes counter and prescaler
// R10: halt plus clear stops counter at zero
// R11: divider select 1..64, code 7 is 64
// R12: high byte read latches low byte buffer
// R13: counter bytes read zero after reset/clear
// R14: period high write inhibits flag until low
// R15: reset sets all period bits
// R16: wait mode keeps counting, irq wakes
// R17: stop mode freezes everything, state kept
// R18: break freezes the counter
// R19: break without clear enable protects status
// R20: break with clear enable allows clearing
// R21: software reads low byte before break ends
// R22: software clears counter before period write
// R23: software leaves halt clear before wait
// R24: irq high while flag and enable set
`timescale 1ns/10ps
`default_nettype none
`include "tick_timer_defines.svh"

module periodic_tick_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             err_o,
    input  wire logic        stop_mode,
    input  wire logic        break_active,
    input  wire logic        break_flag_clear_enable,
    output logic             irq
);

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    logic        req;
    logic        hit;
    logic        lane0;
    logic        take;
    tick_timer_pkg::access_t acc;

    assign req   = cyc_i && stb_i && !ack_o && !err_o;
    assign hit   = (adr_i == `TT_ADDR_CONTROL_STATUS) || (adr_i == `TT_ADDR_COUNT_HIGH)
                || (adr_i == `TT_ADDR_COUNT_LOW) || (adr_i == `TT_ADDR_PERIOD_HIGH)
                || (adr_i == `TT_ADDR_PERIOD_LOW);
    assign lane0 = sel_i[0];
    assign take  = req && hit && !stop_mode;
    assign acc.rd_status      = take && !we_i && adr_i == `TT_ADDR_CONTROL_STATUS;
    assign acc.wr_status      = take && we_i && lane0 && adr_i == `TT_ADDR_CONTROL_STATUS;
    assign acc.rd_count_high  = take && !we_i && adr_i == `TT_ADDR_COUNT_HIGH;
    assign acc.rd_count_low   = take && !we_i && adr_i == `TT_ADDR_COUNT_LOW;
    assign acc.wr_period_high = take && we_i && lane0 && adr_i == `TT_ADDR_PERIOD_HIGH;
    assign acc.wr_period_low  = take && we_i && lane0 && adr_i == `TT_ADDR_PERIOD_LOW;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    tick_timer_pkg::timer_ctrl_t ctrl;
    logic             overflow_flag;
    logic             clear_armed;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] period;
    logic [7:0]       period_high_hold;
    logic             period_inhibit;
    logic [5:0]       prescale;
    logic [7:0]       low_buffer;
    logic             low_latched;

    // ------------------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------------------
    function automatic logic [5:0] div_mask(input logic [2:0] code);
        logic [2:0] c;
        c = (code > `TT_DIV_MAX_CODE) ? `TT_DIV_MAX_CODE : code;
        div_mask = 6'((7'h01 << c) - 7'h01);
    endfunction : div_mask

    logic       clear_now;
    logic       running;
    logic       tick;
    logic       match;
    logic       overflow_event;
    logic [5:0] next_prescale;

    assign clear_now = acc.wr_status && dat_i[`TT_BIT_CLEAR_STROBE]; // see R09
    // frozen by halt, break or stop; wait mode is not an input, so it keeps counting
    assign running   = !ctrl.counter_halt && !break_active && !stop_mode; // see R08 R16 R17 R18
    assign tick      = running && ((prescale & div_mask(ctrl.clock_divider_select))
                                   == div_mask(ctrl.clock_divider_select)); // see R11
    assign match     = (count == period);
    assign overflow_event = tick && match && !period_inhibit; // see R02 R14
    assign next_prescale  = running ? 6'(prescale + 6'h01) : prescale;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prescale <= 6'h00;
            count    <= '0; // see R13
        end else if (clear_now) begin
            prescale <= 6'h00; // see R09 R10
            count    <= '0;
        end else begin
            prescale <= next_prescale;
            if (tick) begin
                // wraps naturally when period is all ones
                count <= match ? '0 : CNT_W'(count + 1'b1); // see R01 R03
            end
        end
    end

    // ------------------------------------------------------------------------
    // control/status register and overflow flag
    // ------------------------------------------------------------------------
    logic status_protect;
    logic flag_clear;

    assign status_protect = break_active && !break_flag_clear_enable; // see R19 R20
    // an overflow in the same cycle wins, and any overflow disarms the pending clear
    assign flag_clear = acc.wr_status && !dat_i[`TT_BIT_OVERFLOW_FLAG] && clear_armed
                     && !status_protect && !overflow_event; // see R04 R05 R06

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl.irq_enable           <= 1'b0; // see R07
            ctrl.counter_halt         <= 1'b1; // see R08
            ctrl.clock_divider_select <= `TT_RESET_DIV; // see R11
        end else if (acc.wr_status) begin
            ctrl.irq_enable           <= dat_i[`TT_BIT_IRQ_ENABLE];
            ctrl.counter_halt         <= dat_i[`TT_BIT_COUNTER_HALT]; // see R10
            ctrl.clock_divider_select <= dat_i[`TT_DIV_MSB:`TT_DIV_LSB];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            overflow_flag <= 1'b0; // see R06
        end else if (overflow_event) begin
            overflow_flag <= 1'b1; // see R02
        end else if (flag_clear) begin
            overflow_flag <= 1'b0; // see R04 R20
        end
    end

    // first step survives a protected break; second step after it completes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clear_armed <= 1'b0;
        end else if (overflow_event || flag_clear) begin
            clear_armed <= 1'b0; // see R05
        end else if (acc.rd_status && overflow_flag && !status_protect) begin
            clear_armed <= 1'b1; // see R04 R19
        end
    end

    // registered so the request pin comes straight from a flop
    logic next_overflow_flag;
    logic next_irq_enable;

    assign next_overflow_flag = overflow_event || (overflow_flag && !flag_clear);
    assign next_irq_enable    = acc.wr_status ? dat_i[`TT_BIT_IRQ_ENABLE] : ctrl.irq_enable;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_overflow_flag && next_irq_enable; // see R07 R16 R24
        end
    end

    // ------------------------------------------------------------------------
    // period registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            period           <= `TT_RESET_PERIOD; // see R15
            period_high_hold <= 8'hFF;
            period_inhibit   <= 1'b0;
        end else if (acc.wr_period_high) begin
            period_high_hold <= dat_i[7:0];
            period_inhibit   <= 1'b1; // see R14
        end else if (acc.wr_period_low) begin
            period         <= {period_high_hold, dat_i[7:0]};
            period_inhibit <= 1'b0; // see R14
        end
    end

    // ------------------------------------------------------------------------
    // counter read latch
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            low_buffer  <= 8'h00;
            low_latched <= 1'b0;
        end else if (clear_now) begin
            low_buffer  <= 8'h00; // see R13
            low_latched <= 1'b0;
        end else if (acc.rd_count_high && !low_latched) begin
            low_buffer  <= count[7:0]; // see R12
            low_latched <= 1'b1;
        end else if (acc.rd_count_low) begin
            low_latched <= 1'b0; // see R12 R21
        end
    end

    // ------------------------------------------------------------------------
    // read mux and answer
    // ------------------------------------------------------------------------
    logic [7:0] rd_byte;
    logic [7:0] status_byte;

    assign status_byte = {overflow_flag, ctrl.irq_enable, ctrl.counter_halt, 1'b0, 1'b0,
                          ctrl.clock_divider_select}; // see R09
    assign rd_byte = (adr_i == `TT_ADDR_CONTROL_STATUS) ? status_byte
                   : (adr_i == `TT_ADDR_COUNT_HIGH)     ? count[15:8]
                   : (adr_i == `TT_ADDR_COUNT_LOW)      ? (low_latched ? low_buffer
                                                                       : count[7:0])
                   : (adr_i == `TT_ADDR_PERIOD_HIGH)    ? period_high_hold
                   : (adr_i == `TT_ADDR_PERIOD_LOW)     ? period[7:0]
                   : 8'h00;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= take;
            err_o <= req && !hit && !stop_mode;
            dat_o <= (take && !we_i) ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_flag_on_match;
        @(posedge core_clk) disable iff (rst)
        overflow_event |=> overflow_flag;
    endproperty
    a_flag_on_match: assert property (p_flag_on_match) else $error("flag not set"); // see R02

    property p_restart_zero;
        @(posedge core_clk) disable iff (rst)
        (tick && match && !clear_now) |=> (count == '0);
    endproperty
    a_restart_zero: assert property (p_restart_zero) else $error("no restart"); // see R03

    sequence s_armed_clear;
        clear_armed ##0 (acc.wr_status && !dat_i[`TT_BIT_OVERFLOW_FLAG] && !status_protect
                         && !overflow_event);
    endsequence
    property p_two_step_clear;
        @(posedge core_clk) disable iff (rst)
        s_armed_clear |=> !overflow_flag;
    endproperty
    a_two_step_clear: assert property (p_two_step_clear) else $error("clear failed"); // see R04

    property p_no_clear_unarmed;
        @(posedge core_clk) disable iff (rst)
        (overflow_flag && !clear_armed) |=> overflow_flag;
    endproperty
    a_no_clear_unarmed: assert property (p_no_clear_unarmed) else $error("lost flag"); // see R05

    property p_irq;
        @(posedge core_clk) disable iff (rst)
        irq == (overflow_flag && ctrl.irq_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch"); // see R24

    property p_halt_holds;
        @(posedge core_clk) disable iff (rst)
        (!running && !clear_now) |=> $stable(count);
    endproperty
    a_halt_holds: assert property (p_halt_holds) else $error("counter moved"); // see R08

    property p_clear_zero;
        @(posedge core_clk) disable iff (rst)
        clear_now |=> (count == '0 && prescale == 6'h00);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear missed"); // see R09

    property p_inhibit;
        @(posedge core_clk) disable iff (rst)
        (period_inhibit && !overflow_flag) |=> !overflow_flag;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit broken"); // see R14

    property p_break_protect;
        @(posedge core_clk) disable iff (rst)
        (status_protect && overflow_flag) |=> overflow_flag;
    endproperty
    a_break_protect: assert property (p_break_protect) else $error("status changed"); // see R19

    property p_count_step;
        @(posedge core_clk) disable iff (rst)
        (tick && !match && !clear_now) |=> (count == CNT_W'($past(count) + 1'b1));
    endproperty
    a_count_step: assert property (p_count_step) else $error("count skipped"); // see R01

    property p_flag_one;
        @(posedge core_clk) disable iff (rst)
        (overflow_flag && acc.wr_status && dat_i[`TT_BIT_OVERFLOW_FLAG]) |=> overflow_flag;
    endproperty
    a_flag_one: assert property (p_flag_one) else $error("flag lost on one"); // see R06

    property p_irq_gated;
        @(posedge core_clk) disable iff (rst)
        !ctrl.irq_enable |-> !irq;
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("irq unmasked"); // see R07

    property p_halt_clear;
        @(posedge core_clk) disable iff (rst)
        (clear_now && dat_i[`TT_BIT_COUNTER_HALT]) |=> (count == '0 && ctrl.counter_halt);
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("halt clear failed"); // see R10

    property p_div_top;
        @(posedge core_clk) disable iff (rst)
        (ctrl.clock_divider_select == 3'h7 && prescale != 6'h3F) |-> !tick;
    endproperty
    a_div_top: assert property (p_div_top) else $error("top code not /64"); // see R11

    sequence s_high_latch;
        acc.rd_count_high && !low_latched && !clear_now;
    endsequence
    property p_latch_copy;
        @(posedge core_clk) disable iff (rst)
        s_high_latch |=> (low_buffer == 8'($past(count)));
    endproperty
    a_latch_copy: assert property (p_latch_copy) else $error("low byte not latched"); // see R12

    property p_latch_hold;
        @(posedge core_clk) disable iff (rst)
        (low_latched && !acc.rd_count_low && !clear_now) |=> $stable(low_buffer);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched byte moved"); // see R12

    property p_clear_latch;
        @(posedge core_clk) disable iff (rst)
        clear_now |=> (!low_latched && low_buffer == 8'h00);
    endproperty
    a_clear_latch: assert property (p_clear_latch) else $error("stale low byte"); // see R13

    property p_inhibit_arm;
        @(posedge core_clk) disable iff (rst)
        acc.wr_period_high |=> period_inhibit;
    endproperty
    a_inhibit_arm: assert property (p_inhibit_arm) else $error("inhibit not set"); // see R14

    property p_stop_quiet;
        @(posedge core_clk) disable iff (rst)
        stop_mode |=> (!ack_o && !err_o);
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("answer in stop"); // see R17

    property p_break_freeze;
        @(posedge core_clk) disable iff (rst)
        (break_active && !clear_now) |=> $stable(count);
    endproperty
    a_break_freeze: assert property (p_break_freeze) else $error("count moved in break"); // see R18

    property p_arm_kept;
        @(posedge core_clk) disable iff (rst)
        (status_protect && clear_armed && !overflow_event) |=> clear_armed;
    endproperty
    a_arm_kept: assert property (p_arm_kept) else $error("arm lost in break"); // see R19

    property p_break_clear;
        @(posedge core_clk) disable iff (rst)
        (break_active && break_flag_clear_enable) ##0 s_armed_clear |=> !overflow_flag;
    endproperty
    a_break_clear: assert property (p_break_clear) else $error("break clear failed"); // see R20

endmodule : periodic_tick_timer
`default_nettype wire

// ==== verilog/tick_timer_defines.svh ====
`ifndef TICK_TIMER_DEFINES_SVH
`define TICK_TIMER_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte addresses (word aligned, data in bits 7:0)
// ----------------------------------------------------------------------------
`define TT_ADDR_CONTROL_STATUS 8'h00
`define TT_ADDR_COUNT_HIGH     8'h04
`define TT_ADDR_COUNT_LOW      8'h08
`define TT_ADDR_PERIOD_HIGH    8'h0C
`define TT_ADDR_PERIOD_LOW     8'h10

// ----------------------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------------------
`define TT_BIT_OVERFLOW_FLAG   7
`define TT_BIT_IRQ_ENABLE      6
`define TT_BIT_COUNTER_HALT    5
`define TT_BIT_CLEAR_STROBE    4
`define TT_DIV_MSB             2
`define TT_DIV_LSB             0

// ----------------------------------------------------------------------------
// reset values and divider code clamp
// ----------------------------------------------------------------------------
`define TT_RESET_PERIOD        16'hFFFF
`define TT_RESET_DIV           3'h0
`define TT_DIV_MAX_CODE        3'h6

`endif

// ==== verilog/tick_timer_pkg.sv ====
package tick_timer_pkg;

    typedef struct packed {
        logic       irq_enable;
        logic       counter_halt;
        logic [2:0] clock_divider_select;
    } timer_ctrl_t;

    typedef struct packed {
        logic rd_status;
        logic wr_status;
        logic rd_count_high;
        logic rd_count_low;
        logic wr_period_high;
        logic wr_period_low;
    } access_t;

endpackage : tick_timer_pkg

// ==== bench/periodic_tick_timer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tick_timer_defines.svh"
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin bad_count++; \
    $display("Error %0t: got %h want %h", $time, g, x); end end

module periodic_tick_timer_tb;
    logic        core_clk, rst, cyc_i, stb_i, we_i, ack_o, err_o, irq;
    logic        stop_mode, break_active, break_flag_clear_enable;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    logic [15:0] c, c2;
    int          bad_count = 0;
    int          cmp_count = 0;

    periodic_tick_timer periodic_tick_timer_i (.core_clk(core_clk), .rst(rst), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .err_o(err_o), .stop_mode(stop_mode), .break_active(break_active),
        .break_flag_clear_enable(break_flag_clear_enable), .irq(irq));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // bus helpers
    // ------------------------------------------------------------------
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // request held until ack or err is sampled at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic e);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h000000, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 100);
        q = dat_o[7:0];
        e = err_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        `CHK(n < 100, 1'b1)
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       e;
        bus(1'b1, a, d, q, e);
    endtask : wr

    task automatic exrd(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] q;
        logic       e;
        bus(1'b0, a, 8'h00, q, e);
        `CHK(q, x)
    endtask : exrd

    task automatic rdcnt(output logic [15:0] v);
        logic e;
        bus(1'b0, `TT_ADDR_COUNT_HIGH, 8'h00, v[15:8], e);
        bus(1'b0, `TT_ADDR_COUNT_LOW, 8'h00, v[7:0], e);
    endtask : rdcnt

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 60) begin
            @(posedge core_clk);
            n++;
        end
        `CHK(irq, 1'b1)
    endtask : wait_irq

    task automatic pause(input int n);
        repeat (n) @(posedge core_clk);
    endtask : pause

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0]  q;
        logic        e;
        logic [15:0] x;
        cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00; sel_i = 4'hF;
        dat_i = 32'h00000000; stop_mode = 1'b0; break_active = 1'b0;
        break_flag_clear_enable = 1'b0; rst = 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        exrd(`TT_ADDR_CONTROL_STATUS, 8'h20);
        pause(10);
        exrd(`TT_ADDR_COUNT_HIGH, 8'h00);
        exrd(`TT_ADDR_COUNT_LOW, 8'h00);
        exrd(`TT_ADDR_PERIOD_HIGH, 8'hFF);
        exrd(`TT_ADDR_PERIOD_LOW, 8'hFF);
        bus(1'b0, 8'h14, 8'h00, q, e);
        `CHK(e, 1'b1)
        $display("test reset done");
        // period 16, run from zero with irq enabled; flag bit kept 1 unless clearing
        wr(`TT_ADDR_PERIOD_HIGH, 8'h00);
        wr(`TT_ADDR_PERIOD_LOW, 8'h10);
        wr(`TT_ADDR_CONTROL_STATUS, 8'hD0);
        wait_irq();
        wr(`TT_ADDR_CONTROL_STATUS, 8'hE0);
        rdcnt(c);
        `CHK(c <= 16'h0010, 1'b1)
        wr(`TT_ADDR_CONTROL_STATUS, 8'h60);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'hE0);
        wr(`TT_ADDR_CONTROL_STATUS, 8'hE0);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'hE0);
        wr(`TT_ADDR_CONTROL_STATUS, 8'h60);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'h60);
        `CHK(irq, 1'b0)
        $display("test flag done");
        // overflow slips in between read and zero write
        wr(`TT_ADDR_CONTROL_STATUS, 8'hD0);
        wait_irq();
        exrd(`TT_ADDR_CONTROL_STATUS, 8'hC0);
        pause(20);
        wr(`TT_ADDR_CONTROL_STATUS, 8'h60);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'hE0);
        wr(`TT_ADDR_CONTROL_STATUS, 8'h60);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'h60);
        $display("test race done");
        wr(`TT_ADDR_CONTROL_STATUS, 8'h90);
        pause(40);
        `CHK(irq, 1'b0)
        wr(`TT_ADDR_CONTROL_STATUS, 8'hA0);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'hA0);
        wr(`TT_ADDR_CONTROL_STATUS, 8'hE0);
        `CHK(irq, 1'b1)
        wr(`TT_ADDR_CONTROL_STATUS, 8'h20);
        `CHK(irq, 1'b0)
        $display("test mask done");
        wr(`TT_ADDR_PERIOD_HIGH, 8'h00);
        wr(`TT_ADDR_CONTROL_STATUS, 8'h90);
        pause(60);
        wr(`TT_ADDR_CONTROL_STATUS, 8'hA0);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'h20);
        wr(`TT_ADDR_PERIOD_LOW, 8'h10);
        wr(`TT_ADDR_CONTROL_STATUS, 8'h90);
        pause(40);
        wr(`TT_ADDR_CONTROL_STATUS, 8'hA0);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'hA0);
        $display("test inhibit done");
        // leave a nonzero low byte latched; the clear must drop it
        bus(1'b0, `TT_ADDR_COUNT_HIGH, 8'h00, q, e);
        wr(`TT_ADDR_CONTROL_STATUS, 8'hB0);
        exrd(`TT_ADDR_COUNT_HIGH, 8'h00);
        exrd(`TT_ADDR_COUNT_LOW, 8'h00);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'hA0);
        pause(10);
        exrd(`TT_ADDR_COUNT_LOW, 8'h00);
        $display("test clear done");
        // high read latches low byte zero; counter then moves on
        exrd(`TT_ADDR_COUNT_HIGH, 8'h00);
        wr(`TT_ADDR_CONTROL_STATUS, 8'h80);
        pause(25);
        wr(`TT_ADDR_CONTROL_STATUS, 8'hA0);
        exrd(`TT_ADDR_COUNT_HIGH, 8'h00);
        exrd(`TT_ADDR_COUNT_LOW, 8'h00);
        bus(1'b0, `TT_ADDR_COUNT_LOW, 8'h00, q, e);
        `CHK(q != 8'h00, 1'b1)
        $display("test latch done");
        wr(`TT_ADDR_PERIOD_HIGH, 8'hFF);
        wr(`TT_ADDR_PERIOD_LOW, 8'hFF);
        for (int k = 0; k < 8; k++) begin
            wr(`TT_ADDR_CONTROL_STATUS, 8'hB0);
            wr(`TT_ADDR_CONTROL_STATUS, 8'h80 | k[7:0]);
            pause(189);
            wr(`TT_ADDR_CONTROL_STATUS, 8'hA0 | k[7:0]);
            rdcnt(c);
            x = 16'h00C0 >> ((k > 6) ? 6 : k);
            `CHK((c + 16'h0002 >= x) && (c <= x + 16'h0002), 1'b1)
        end
        $display("test divider done");
        wr(`TT_ADDR_CONTROL_STATUS, 8'hB0);
        wr(`TT_ADDR_PERIOD_HIGH, 8'h00);
        wr(`TT_ADDR_PERIOD_LOW, 8'h10);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'hA0);
        break_active <= 1'b1;
        wr(`TT_ADDR_CONTROL_STATUS, 8'h80);
        rdcnt(c);
        pause(10);
        rdcnt(c2);
        `CHK(c2, c)
        wr(`TT_ADDR_CONTROL_STATUS, 8'h20);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'hA0);
        break_active <= 1'b0;
        wr(`TT_ADDR_CONTROL_STATUS, 8'h20);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'h20);
        wr(`TT_ADDR_CONTROL_STATUS, 8'h90);
        pause(30);
        break_active <= 1'b1;
        break_flag_clear_enable <= 1'b1;
        exrd(`TT_ADDR_CONTROL_STATUS, 8'h80);
        wr(`TT_ADDR_CONTROL_STATUS, 8'h20);
        break_active <= 1'b0;
        break_flag_clear_enable <= 1'b0;
        pause(5);
        exrd(`TT_ADDR_CONTROL_STATUS, 8'h20);
        $display("test break done");
        // request posted during stop must wait for stop to end
        stop_mode <= 1'b1;
        fork
            bus(1'b0, `TT_ADDR_CONTROL_STATUS, 8'h00, q, e);
            begin
                pause(6);
                `CHK(ack_o, 1'b0)
                stop_mode <= 1'b0;
            end
        join
        `CHK(q, 8'h20)
        $display("test stop done");
        // reset in mid-run with the flag and request up
        wr(`TT_ADDR_CONTROL_STATUS, 8'hD0);
        wait_irq();
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        `CHK(irq, 1'b0)
        exrd(`TT_ADDR_CONTROL_STATUS, 8'h20);
        exrd(`TT_ADDR_COUNT_LOW, 8'h00);
        exrd(`TT_ADDR_PERIOD_LOW, 8'hFF);
        $display("test rerun done");
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        $display("Error %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : periodic_tick_timer_tb
`default_nettype wire
